// ==== verilog/fpc_pkg.sv ====
// Purpose: Shared constants and types for the flash protection and status block
// Assumes: 8-bit register port, 16-bit flash addresses
// Notes: Offsets are register indexes on the plain port
package fpc_pkg;

  // ----------------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------------
  localparam logic [3:0] FPC_OFF_CONFIG = 4'h3;
  localparam logic [3:0] FPC_OFF_PROT = 4'h4;
  localparam logic [3:0] FPC_OFF_STATUS = 4'h5;

  // ----------------------------------------------------------------------
  // Protection register fields
  // ----------------------------------------------------------------------
  localparam int FPC_PROT_POL = 7;
  localparam int FPC_PROT_NV6 = 6;
  localparam int FPC_PROT_HDIS = 5;
  localparam int FPC_PROT_HS_LSB = 3;
  localparam int FPC_PROT_LDIS = 2;
  localparam int FPC_PROT_LS_LSB = 0;
  localparam logic [7:0] FPC_PROT_RST = 8'hFF;

  // ----------------------------------------------------------------------
  // Status and configuration fields
  // ----------------------------------------------------------------------
  localparam int FPC_ST_BEMPTY = 7;
  localparam int FPC_ST_CDONE = 6;
  localparam int FPC_ST_PROTECTION_VIOLATION_FLAG = 5;
  localparam int FPC_ST_ACCESS_ERROR_FLAG = 4;
  localparam int FPC_ST_BLANK = 2;
  localparam int FPC_ST_FAIL = 1;
  localparam int FPC_ST_IDLE = 0;
  localparam int FPC_CFG_BE_IE = 7;
  localparam int FPC_CFG_CC_IE = 6;
  localparam logic [7:0] FPC_CFG_RST = 8'h00;

  // ----------------------------------------------------------------------
  // Window bounds
  // ----------------------------------------------------------------------
  localparam logic [15:0] FPC_HIGH_BASE_2K = 16'hF800;
  localparam logic [15:0] FPC_HIGH_BASE_4K = 16'hF000;
  localparam logic [15:0] FPC_HIGH_BASE_8K = 16'hE000;
  localparam logic [15:0] FPC_HIGH_BASE_16K = 16'hC000;
  localparam logic [15:0] FPC_LOW_BASE = 16'h4000;
  localparam logic [15:0] FPC_LOW_LAST_512 = 16'h41FF;
  localparam logic [15:0] FPC_LOW_LAST_1K = 16'h43FF;
  localparam logic [15:0] FPC_LOW_LAST_2K = 16'h47FF;
  localparam logic [15:0] FPC_LOW_LAST_4K = 16'h4FFF;

  // Allowed targets per scenario, bit n set means scenario n allowed
  localparam logic [63:0] FPC_ALLOWED = {8'hFF, 8'h5A, 8'h3C, 8'h18,
                                         8'h08, 8'h0C, 8'h0A, 8'h0F};

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [0:0] {
    FPC_SEQ_IDLE = 1'b0,
    FPC_SEQ_WORD = 1'b1
  } fpc_seq_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } fpc_bus_req_t;

  typedef struct packed {
    logic word_write;
    logic [15:0] word_addr;
    logic cmd_finish;
    logic cmd_error;
    logic verify_fail;
    logic verify_blank;
  } fpc_eng_evt_t;

endpackage

// ==== verilog/fpc_core.sv ====
// Purpose: Flash protection windows and command status flags
// Assumes: Engine and sequence events come from logic on clk
// Notes: One active and one pending command slot
//
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none

module fpc_core
  import fpc_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire fpc_bus_req_t bus_req,
  output logic [7:0] reg_rdata,
  input wire logic special_mode,
  input wire logic prot_load_valid,
  input wire logic [7:0] prot_load_data,
  input wire fpc_eng_evt_t eng_evt,
  output logic cmd_start,
  output logic irq_req,
  output logic word_protected
);

  // ----------------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------------
  // Window bits swap places between the two polarity halves of the list
  function automatic logic [2:0] fpc_scenario(input logic [7:0] p);
    if (p[FPC_PROT_POL]) begin
      fpc_scenario = {1'b0, ~p[FPC_PROT_HDIS], ~p[FPC_PROT_LDIS]};
    end else begin
      fpc_scenario = {1'b1, ~p[FPC_PROT_LDIS], ~p[FPC_PROT_HDIS]};
    end
  endfunction

  function automatic logic fpc_allowed(input logic [2:0] from_s, input logic [2:0] to_s);
    fpc_allowed = FPC_ALLOWED[{from_s, to_s}];
  endfunction

  function automatic logic fpc_is_protected(input logic [7:0] p, input logic [15:0] a);
    logic [15:0] hbase;
    logic [15:0] llast;
    logic in_high;
    logic in_low;
    logic sel;
    hbase = FPC_HIGH_BASE_2K;
    llast = FPC_LOW_LAST_512;
    case (p[FPC_PROT_HS_LSB +: 2])
      2'b00: hbase = FPC_HIGH_BASE_2K;
      2'b01: hbase = FPC_HIGH_BASE_4K;
      2'b10: hbase = FPC_HIGH_BASE_8K;
      default: hbase = FPC_HIGH_BASE_16K;
    endcase
    case (p[FPC_PROT_LS_LSB +: 2])
      2'b00: llast = FPC_LOW_LAST_512;
      2'b01: llast = FPC_LOW_LAST_1K;
      2'b10: llast = FPC_LOW_LAST_2K;
      default: llast = FPC_LOW_LAST_4K;
    endcase
    in_high = (a >= hbase);
    in_low = (a >= FPC_LOW_BASE) && (a <= llast);
    sel = (~p[FPC_PROT_HDIS] & in_high) | (~p[FPC_PROT_LDIS] & in_low);
    if (p[FPC_PROT_POL]) begin
      fpc_is_protected = sel;
    end else begin
      fpc_is_protected = ~sel;
    end
  endfunction

  // ----------------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------------
  logic wr_prot;
  logic wr_stat;
  logic wr_cfg;
  logic [7:0] wd;
  assign wd = bus_req.wdata;
  assign wr_prot = bus_req.wr && (bus_req.addr == FPC_OFF_PROT);
  assign wr_stat = bus_req.wr && (bus_req.addr == FPC_OFF_STATUS);
  assign wr_cfg = bus_req.wr && (bus_req.addr == FPC_OFF_CONFIG);

  logic [7:0] prot_reg;
  logic [7:0] cfg_reg;
  logic bempty_reg;
  logic cdone_reg;
  logic protection_violation_flag_reg;
  logic access_error_flag_reg;
  logic blank_reg;
  logic fail_reg;
  logic active_reg;
  logic pend_reg;
  fpc_seq_t seq_reg;

  // ----------------------------------------------------------------------
  // Protection register
  // ----------------------------------------------------------------------
  logic [7:0] prot_next;
  always_comb begin
    prot_next = prot_reg;
    prot_next[FPC_PROT_POL] = wd[FPC_PROT_POL];
    prot_next[FPC_PROT_HDIS] = wd[FPC_PROT_HDIS];
    prot_next[FPC_PROT_LDIS] = wd[FPC_PROT_LDIS];
    if (prot_reg[FPC_PROT_HDIS]) begin
      prot_next[FPC_PROT_HS_LSB +: 2] = wd[FPC_PROT_HS_LSB +: 2];
    end
    if (prot_reg[FPC_PROT_LDIS]) begin
      prot_next[FPC_PROT_LS_LSB +: 2] = wd[FPC_PROT_LS_LSB +: 2];
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      prot_reg <= FPC_PROT_RST;
    end else if (prot_load_valid) begin
      prot_reg <= prot_load_data;
    end else if (wr_prot && fpc_allowed(fpc_scenario(prot_reg), fpc_scenario(prot_next))) begin
      prot_reg <= prot_next;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cfg_reg <= FPC_CFG_RST;
    end else if (wr_cfg) begin
      cfg_reg <= {wd[FPC_CFG_BE_IE], wd[FPC_CFG_CC_IE], 6'h00};
    end
  end

  // ----------------------------------------------------------------------
  // Command write sequence
  // ----------------------------------------------------------------------
  logic hit_prot;
  logic errs_block;
  logic launch;
  logic abort_zero;
  logic start_now;
  assign hit_prot = fpc_is_protected(prot_reg, eng_evt.word_addr);
  assign errs_block = protection_violation_flag_reg | access_error_flag_reg | (special_mode & fail_reg);
  assign launch = wr_stat && wd[FPC_ST_BEMPTY] && bempty_reg
                  && (seq_reg == FPC_SEQ_WORD) && !errs_block;
  assign abort_zero = wr_stat && !wd[FPC_ST_BEMPTY] && (seq_reg == FPC_SEQ_WORD);
  assign start_now = (launch && !active_reg) || (eng_evt.cmd_finish && pend_reg);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      seq_reg <= FPC_SEQ_IDLE;
    end else begin
      case (seq_reg)
        FPC_SEQ_IDLE: begin
          if (eng_evt.word_write && bempty_reg && !errs_block && !hit_prot) begin
            seq_reg <= FPC_SEQ_WORD;
          end
        end
        FPC_SEQ_WORD: begin
          if (launch || abort_zero || eng_evt.cmd_error || (wr_stat && wd[FPC_ST_BEMPTY])) begin
            seq_reg <= FPC_SEQ_IDLE;
          end
        end
        default: seq_reg <= FPC_SEQ_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Command slots
  // ----------------------------------------------------------------------
  logic active_next;
  logic pend_next;
  always_comb begin
    active_next = active_reg;
    pend_next = pend_reg;
    if (eng_evt.cmd_finish && active_reg) begin
      active_next = pend_reg;
      pend_next = 1'b0;
    end
    if (launch) begin
      if (active_next && !(eng_evt.cmd_finish && pend_reg)) begin
        pend_next = active_reg;
        active_next = 1'b1;
      end else begin
        active_next = 1'b1;
        pend_next = active_reg && !eng_evt.cmd_finish ? 1'b1 : pend_next;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      active_reg <= 1'b0;
      pend_reg <= 1'b0;
    end else begin
      active_reg <= active_next;
      pend_reg <= pend_next;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cmd_start <= 1'b0;
    end else begin
      cmd_start <= start_now;
    end
  end

  // ----------------------------------------------------------------------
  // Status flags
  // ----------------------------------------------------------------------
  logic bempty_next;
  assign bempty_next = launch ? 1'b0 : (!pend_next ? 1'b1 : bempty_reg);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      bempty_reg <= 1'b1;
    end else begin
      bempty_reg <= bempty_next;
    end
  end

  // Tracks next state so a fetched pending command keeps it low
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cdone_reg <= 1'b1;
    end else begin
      cdone_reg <= bempty_next && !active_next && !pend_next;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      protection_violation_flag_reg <= 1'b0;
    end else if (eng_evt.word_write && (seq_reg == FPC_SEQ_IDLE) && bempty_reg && hit_prot) begin
      protection_violation_flag_reg <= 1'b1;
    end else if (wr_stat && wd[FPC_ST_PROTECTION_VIOLATION_FLAG]) begin
      protection_violation_flag_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      access_error_flag_reg <= 1'b0;
    end else if (abort_zero || eng_evt.cmd_error) begin
      access_error_flag_reg <= 1'b1;
    end else if (wr_stat && wd[FPC_ST_ACCESS_ERROR_FLAG]) begin
      access_error_flag_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      blank_reg <= 1'b0;
    end else if (eng_evt.verify_blank) begin
      blank_reg <= 1'b1;
    end else if (launch) begin
      blank_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      fail_reg <= 1'b0;
    end else if (special_mode && eng_evt.verify_fail) begin
      fail_reg <= 1'b1;
    end else if (special_mode && wr_stat && wd[FPC_ST_FAIL]) begin
      fail_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Read port and outputs
  // ----------------------------------------------------------------------
  logic [7:0] stat_view;
  always_comb begin
    stat_view = 8'h00;
    stat_view[FPC_ST_BEMPTY] = bempty_reg;
    stat_view[FPC_ST_CDONE] = cdone_reg;
    stat_view[FPC_ST_PROTECTION_VIOLATION_FLAG] = protection_violation_flag_reg;
    stat_view[FPC_ST_ACCESS_ERROR_FLAG] = access_error_flag_reg;
    stat_view[FPC_ST_BLANK] = blank_reg;
    stat_view[FPC_ST_FAIL] = special_mode & fail_reg;
    stat_view[FPC_ST_IDLE] = special_mode & ~active_reg;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      reg_rdata <= 8'h00;
    end else if (bus_req.rd) begin
      case (bus_req.addr)
        FPC_OFF_PROT: reg_rdata <= prot_reg;
        FPC_OFF_STATUS: reg_rdata <= stat_view;
        FPC_OFF_CONFIG: reg_rdata <= cfg_reg;
        default: reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irq_req <= 1'b0;
    end else begin
      irq_req <= (bempty_reg & cfg_reg[FPC_CFG_BE_IE])
               | (cdone_reg & cfg_reg[FPC_CFG_CC_IE]);
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      word_protected <= 1'b0;
    end else begin
      word_protected <= hit_prot;
    end
  end

endmodule

`default_nettype wire

// ==== sim/fpc_core_checker.sv ====
// Purpose: Port assertions for fpc_core
// Assumes: One clock, synchronous active-high reset
// Notes: Config register mirrored from bus writes
`timescale 1ns/1ns
`default_nettype none
module fpc_core_checker
  import fpc_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire fpc_bus_req_t bus_req,
  input wire logic [7:0] reg_rdata,
  input wire logic special_mode,
  input wire logic prot_load_valid,
  input wire logic [7:0] prot_load_data,
  input wire fpc_eng_evt_t eng_evt,
  input wire logic cmd_start,
  input wire logic irq_req,
  input wire logic word_protected
);
  // ----------
  // Checks
  // ----------
  logic [7:0] cfg_reg;
  logic st_wr;
  assign st_wr = bus_req.wr && bus_req.addr == FPC_OFF_STATUS;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cfg_reg <= FPC_CFG_RST;
    end else if (bus_req.wr && bus_req.addr == FPC_OFF_CONFIG) begin
      cfg_reg <= bus_req.wdata;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  rdata_idle_a: assert property (!$past(bus_req.rd) |-> reg_rdata == 8'h00)
    else $error("read data not zero outside a read answer");
  start_cause_a: assert property (cmd_start |->
    ($past(st_wr && bus_req.wdata[FPC_ST_BEMPTY]) || $past(eng_evt.cmd_finish)))
    else $error("command start without launch or finish");
  start_one_a: assert property (cmd_start |=> !cmd_start)
    else $error("command start longer than one cycle");
  zero_write_a: assert property (
    st_wr && !bus_req.wdata[FPC_ST_BEMPTY] && !eng_evt.cmd_finish |=> !cmd_start)
    else $error("zero write launched a command");
  irq_be_a: assert property (
    irq_req && !$past(cfg_reg[FPC_CFG_CC_IE]) |-> $past(cfg_reg[FPC_CFG_BE_IE]))
    else $error("irq without buffer-empty enable");
  irq_cc_a: assert property (
    irq_req && !$past(cfg_reg[FPC_CFG_BE_IE]) |-> $past(cfg_reg[FPC_CFG_CC_IE]))
    else $error("irq without complete enable");
  status_zero_a: assert property (
    bus_req.rd && bus_req.addr == FPC_OFF_STATUS && !special_mode
    |=> (reg_rdata & 8'h0B) == 8'h00) else $error("status low bits not zero");
  prot_load_a: assert property (prot_load_valid ##2
    (bus_req.rd && bus_req.addr == FPC_OFF_PROT) |=> reg_rdata == $past(prot_load_data, 3))
    else $error("loaded protection not read back");
endmodule
bind fpc_core fpc_core_checker fpc_core_checker_i (.clk(clk), .sys_rst(sys_rst),
  .bus_req(bus_req), .reg_rdata(reg_rdata), .special_mode(special_mode),
  .prot_load_valid(prot_load_valid), .prot_load_data(prot_load_data), .eng_evt(eng_evt),
  .cmd_start(cmd_start), .irq_req(irq_req), .word_protected(word_protected));
`default_nettype wire

// ==== sim/fpc_core_tb_top.sv ====
// Purpose: Self-checking bench for fpc_core
// Assumes: Bench drives all ports directly
// Notes: Command starts are counted, not timed
`timescale 1ns/1ns
`default_nettype none
module fpc_core_tb_top
  import fpc_pkg::*;
;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  fpc_bus_req_t bus_req = '0;
  logic special_mode = 1'b0;
  logic prot_load_valid = 1'b0;
  logic [7:0] prot_load_data = 8'h00;
  fpc_eng_evt_t eng_evt = '0;
  logic [7:0] reg_rdata;
  logic cmd_start;
  logic irq_req;
  logic word_protected;
  int err_count = 0;
  int cmp_count = 0;
  int starts = 0;
  int cyc = 0;
  int n;
  localparam logic [7:0] OK_TO [8] = '{8'h0F, 8'h0A, 8'h0C, 8'h08, 8'h18, 8'h3C, 8'h5A, 8'hFF};
  // Protection byte, address, expected protected bit
  localparam logic [27:0] WIN [24] = '{28'hC4F8001, 28'hC4F7FF0, 28'hCCF0001, 28'hCCEFFF0,
    28'hD4E0001, 28'hD4DFFF0, 28'hDCC0001, 28'hDCBFFF0, 28'hE041FF1, 28'hE042000,
    28'hE143FF1, 28'hE144000, 28'hE247FF1, 28'hE248000, 28'hE34FFF1, 28'hE350000,
    28'h7F80001, 28'h5CC0000, 28'h5CBFFF1, 28'h634FFF0, 28'h6350001, 28'h40F8000,
    28'h4080001, 28'hC040001};
  always #50 clk = ~clk;
  fpc_core fpc_core_i (.clk(clk), .sys_rst(sys_rst), .bus_req(bus_req),
    .reg_rdata(reg_rdata), .special_mode(special_mode), .prot_load_valid(prot_load_valid),
    .prot_load_data(prot_load_data), .eng_evt(eng_evt), .cmd_start(cmd_start),
    .irq_req(irq_req), .word_protected(word_protected));
  // ----------
  // Bus and event tasks
  // ----------
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cmd_start === 1'b1) starts++;
    if (cyc == 5000) begin
      err_count++;
      conclude();
    end
  end
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    bus_req.addr <= a;
    bus_req.wdata <= d;
    bus_req.wr <= 1'b1;
    @(posedge clk);
    bus_req.wr <= 1'b0;
  endtask
  task automatic rchk(input logic [3:0] a, input logic [7:0] exp, input string what);
    @(posedge clk);
    bus_req.addr <= a;
    bus_req.rd <= 1'b1;
    @(posedge clk);
    bus_req.rd <= 1'b0;
    #1;
    chk(what, exp, reg_rdata);
  endtask
  task automatic ld(input logic [7:0] d);
    @(posedge clk);
    prot_load_valid <= 1'b1;
    prot_load_data <= d;
    @(posedge clk);
    prot_load_valid <= 1'b0;
  endtask
  // Bits: word write, finish, error, verify fail
  task automatic ev(input logic [3:0] k);
    @(posedge clk);
    eng_evt <= {k[3], eng_evt.word_addr, k[2:0], 1'b0};
    @(posedge clk);
    eng_evt <= {1'b0, eng_evt.word_addr, 4'h0};
  endtask
  task automatic irq_chk(input logic e);
    repeat (3) @(posedge clk);
    #1;
    chk("irq_req", {7'h00, e}, {7'h00, irq_req});
  endtask
  task automatic st_chk(input int c);
    repeat (2) @(posedge clk);
    #1;
    chk("cmd_start count", 8'(c), 8'(starts));
  endtask
  function automatic logic [7:0] enc(input int s);
    logic [1:0] hl;
    hl = (s % 4 == 0) ? 2'b11 : (s % 4 == 3) ? 2'b00 : (s == 1 || s == 6) ? 2'b10 : 2'b01;
    return {s < 4, 1'b1, hl[1], 2'b11, hl[0], 2'b11};
  endfunction
  // ----------
  // Tests
  // ----------
  task automatic t_win();
    for (int i = 0; i < 24; i++) begin
      ld(WIN[i][27:20]);
      rchk(FPC_OFF_PROT, WIN[i][27:20], "prot load");
      @(posedge clk);
      eng_evt.word_addr <= WIN[i][19:4];
      repeat (3) @(posedge clk);
      #1;
      chk("word_protected", {7'h00, WIN[i][0]}, {7'h00, word_protected});
    end
    $display("test windows done");
  endtask
  task automatic t_trans();
    for (int s = 0; s < 8; s++) begin
      for (int t = 0; t < 8; t++) begin
        ld(enc(s));
        wr(FPC_OFF_PROT, enc(t));
        rchk(FPC_OFF_PROT, OK_TO[s][t] ? enc(t) : enc(s), "prot move");
      end
    end
    ld(8'hC4);
    wr(FPC_OFF_PROT, 8'hDF);
    rchk(FPC_OFF_PROT, 8'hC7, "size fields");
    $display("test transitions done");
  endtask
  task automatic t_cmd();
    ld(8'hFF);
    rchk(FPC_OFF_STATUS, 8'hC0, "status idle");
    rchk(4'h0, 8'h00, "unmapped");
    wr(FPC_OFF_CONFIG, 8'h80);
    irq_chk(1'b1);
    n = starts;
    ev(4'h8);
    wr(FPC_OFF_STATUS, 8'h80);
    st_chk(n + 1);
    rchk(FPC_OFF_STATUS, 8'h80, "status busy");
    ev(4'h8);
    wr(FPC_OFF_STATUS, 8'h80);
    st_chk(n + 1);
    rchk(FPC_OFF_STATUS, 8'h00, "status full");
    irq_chk(1'b0);
    ev(4'h4);
    st_chk(n + 2);
    rchk(FPC_OFF_STATUS, 8'h80, "status pending");
    wr(FPC_OFF_STATUS, 8'h40);
    rchk(FPC_OFF_STATUS, 8'h80, "complete write");
    wr(FPC_OFF_CONFIG, 8'h40);
    irq_chk(1'b0);
    ev(4'h4);
    rchk(FPC_OFF_STATUS, 8'hC0, "status done");
    irq_chk(1'b1);
    $display("test commands done");
  endtask
  task automatic t_err();
    wr(FPC_OFF_STATUS, 8'h00);
    rchk(FPC_OFF_STATUS, 8'hC0, "zero outside");
    ev(4'h8);
    wr(FPC_OFF_STATUS, 8'h00);
    rchk(FPC_OFF_STATUS, 8'hD0, "abort");
    n = starts;
    ev(4'h8);
    wr(FPC_OFF_STATUS, 8'h80);
    st_chk(n);
    wr(FPC_OFF_STATUS, 8'h10);
    rchk(FPC_OFF_STATUS, 8'hC0, "error clear");
    ld(8'h7F);
    ev(4'h8);
    rchk(FPC_OFF_STATUS, 8'hE0, "violation");
    ld(8'hFF);
    ev(4'h8);
    wr(FPC_OFF_STATUS, 8'h80);
    st_chk(n);
    wr(FPC_OFF_STATUS, 8'h20);
    rchk(FPC_OFF_STATUS, 8'hC0, "violation clear");
    $display("test errors done");
  endtask
  task automatic t_mode();
    @(posedge clk);
    special_mode <= 1'b1;
    rchk(FPC_OFF_STATUS, 8'hC1, "special idle");
    ev(4'h1);
    rchk(FPC_OFF_STATUS, 8'hC3, "special fail");
    wr(FPC_OFF_STATUS, 8'h02);
    rchk(FPC_OFF_STATUS, 8'hC1, "fail clear");
    @(posedge clk);
    special_mode <= 1'b0;
    ev(4'h1);
    rchk(FPC_OFF_STATUS, 8'hC0, "normal fail");
    @(posedge clk);
    eng_evt.verify_blank <= 1'b1;
    @(posedge clk);
    eng_evt.verify_blank <= 1'b0;
    rchk(FPC_OFF_STATUS, 8'hC4, "blank set");
    wr(FPC_OFF_STATUS, 8'h04);
    rchk(FPC_OFF_STATUS, 8'hC4, "blank write");
    $display("test modes done");
  endtask
  initial begin
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    rchk(FPC_OFF_PROT, FPC_PROT_RST, "prot reset");
    rchk(FPC_OFF_CONFIG, FPC_CFG_RST, "config reset");
    rchk(FPC_OFF_STATUS, 8'hC0, "status reset");
    t_win();
    t_trans();
    t_cmd();
    t_err();
    t_mode();
    conclude();
  end
endmodule
`default_nettype wire
